/* hdl/ems_defines.svh */
// Offsets, field positions, reset values and counts of the external memory select block
`ifndef EMS_DEFINES_SVH
`define EMS_DEFINES_SVH
// Register byte offsets
`define EMS_OFF_WAIT 12'h000
`define EMS_OFF_SELCTL 12'h004
`define EMS_OFF_OVLAY 12'h008
`define EMS_OFF_STATUS 12'h00c
`define EMS_OFF_REQ 12'h010
`define EMS_OFF_ADDR 12'h014
`define EMS_OFF_FLAG 12'h018
// Wait register fields
`define EMS_WAIT_IO_LSB 0
`define EMS_WAIT_DATA_LSB 12
`define EMS_WAIT_MODE_BIT 15
`define EMS_WAIT_RESET 32'h0000_7fff
// Select control: combined-select enables in bits 3:0 (program, data, byte, io)
`define EMS_EN_PROG 0
`define EMS_EN_DATA 1
`define EMS_EN_BYTE 2
`define EMS_EN_IO 3
`define EMS_SELCTL_RESET 4'hb
`define EMS_BYTE_SEL_EN_BIT 4
// Overlay register fields
`define EMS_OVL_PROG_LSB 0
`define EMS_OVL_DATA_LSB 4
// Overlay codes
`define EMS_OVL_EXT1 3'h1
`define EMS_OVL_EXT2 3'h2
// External window and io regions
`define EMS_WIN_BASE 14'h2000
`define EMS_WIN_TOP 14'h3fff
`define EMS_IO_REGION_BITS 2
`define EMS_IO_ADDR_BITS 11
// Unmapped read value
`define EMS_UNMAPPED 32'h0000_0000
`endif

/* hdl/ems_ovl_decode.sv */
// Overlay field decode onto internal memory or one of two external overlays
`timescale 1ns/10ps
`include "ems_defines.svh"
module ems_ovl_decode (
  input wire logic is_prog,
  input wire logic [2:0] ovl,
  output logic external,
  output logic addr13
);
  // Values 1 and 2 go out, everything else stays on chip
  always_comb begin
    external = (ovl == `EMS_OVL_EXT1) || (ovl == `EMS_OVL_EXT2); // RL7 RL8
    addr13 = (ovl == `EMS_OVL_EXT2);
    if (is_prog && ovl > 3'h5) begin
      external = 1'b0; // RL7
    end
  end
endmodule

/* hdl/ems_pkg.sv */
// Types shared by the external memory select block
package ems_pkg;
  typedef enum logic [3:0] {
    EMS_SPACE_PROG = 4'h1,
    EMS_SPACE_DATA = 4'h2,
    EMS_SPACE_BYTE = 4'h4,
    EMS_SPACE_IO = 4'h8
  } ems_space_t;
  typedef struct packed {
    logic prog_n;
    logic data_n;
    logic byte_n;
    logic io_n;
    logic comb_n;
  } ems_sel_t;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } ems_apb_req_t;
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } ems_apb_rsp_t;
endpackage

/* hdl/ems_top.sv */
// External memory select, overlay decode and wait-state sequencing over APB
// Function
// RL1 - Memory mode is caught from the shared pin during reset; pin then becomes flag two.
// RL2 - Outside driver of the mode level drives only while reset is low.
// RL3 - Host mode, strap 0: acknowledge driven both ways.
// RL4 - Host mode, strap 1: acknowledge is open-source, needs pull-down.
// RL5 - Full mode program space: 24-bit, 32K internal, two 8K overlays.
// RL6 - Host mode: overlays use only lowest address line, no external execution.
// RL7 - Program overlay 0,4,5 internal; 1 overlay one; 2 overlay two, bit 13 high.
// RL8 - Data overlay 0,4-7 internal; 1 and 2 select external overlays.
// RL9 - Internal data accesses complete in one cycle.
// RL10 - External data accesses stretched by the data wait field.
// RL11 - Mode bit 0 gives N waits; 1 gives 2N+1 up to 15.
// RL12 - Io space 2048 words on eleven address lines; upper three undefined.
// RL13 - Each of four io regions uses its own three-bit wait field.
// RL14 - Combined select has the same timing as the individual selects.
// RL15 - Combined select asserts with each enabled individual select.
// RL16 - Combined select obeys the same bus request logic.
// RL17 - At reset all combined enables are 1 except the byte one.
// RL18 - Mode pin 1 at reset means host mode, 0 full mode.
// RL19 - Byte select enabled at reset; software may disable it.
// RL20 - Selects and strobes held steady until the wait count has elapsed.
`timescale 1ns/10ps
`include "ems_defines.svh"
module ems_top
  import ems_pkg::*;
#(
  parameter int REGIONS = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire ems_pkg::ems_apb_req_t apb_req,
  output ems_pkg::ems_apb_rsp_t apb_rsp,
  input wire logic mode_pin_in,
  input wire logic ack_strap,
  output logic flag_pin_two_out,
  output logic flag_pin_two_oe_n,
  input wire logic host_port_ack_req,
  output logic host_port_ack_out,
  output logic host_port_ack_oe_n,
  input wire logic bus_request,
  output logic bus_grant,
  output ems_pkg::ems_sel_t selects,
  output logic [13:0] ext_addr,
  output logic rd_strobe_n,
  output logic wr_strobe_n,
  output logic access_done
);
  import ems_pkg::*;
  initial begin
    if (REGIONS != 4) $error("ems_top: four io regions only");
  end

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_DONE = 3'b100
  } ems_state_t;

  typedef struct packed {
    ems_state_t state;
    logic caught;
    logic host_mode;
    logic ack_mode;
    logic [15:0] wait_cfg;
    logic [4:0] sel_cfg;
    logic [7:0] ovl_cfg;
    logic [31:0] addr_cfg;
    logic [3:0] count;
    logic [3:0] space;
    logic is_write;
    logic ext_hit;
    logic flag_out;
    logic flag_oe;
    logic granted;
    ems_apb_rsp_t rsp;
    ems_sel_t sel;
    logic [13:0] addr;
    logic rd_n;
    logic wr_n;
    logic done;
    logic ack_out;
    logic ack_oe_n;
  } ems_regs_t;

  ems_regs_t st_reg;
  ems_regs_t st_next;
  logic [3:0] wait_cycles;
  logic ovl_ext;
  logic ovl_a13;
  logic [2:0] cur_ovl;
  logic cur_prog;
  logic cur_io;
  logic req_go;
  logic [3:0] req_space;
  logic apb_take;
  logic [3:0] sel_vec;

  // Current access space and its overlay field
  always_comb begin
    cur_prog = st_reg.space == EMS_SPACE_PROG;
    cur_io = st_reg.space == EMS_SPACE_IO;
    cur_ovl = cur_prog ? st_reg.ovl_cfg[`EMS_OVL_PROG_LSB +: 3] : st_reg.ovl_cfg[`EMS_OVL_DATA_LSB +: 3];
  end

  ems_ovl_decode u_ovl (
    .is_prog(cur_prog),
    .ovl(cur_ovl),
    .external(ovl_ext),
    .addr13(ovl_a13)
  );

  ems_wait_calc #(.REGIONS(REGIONS)) u_wait (
    .wait_mode(st_reg.wait_cfg[`EMS_WAIT_MODE_BIT]),
    .is_io(cur_io),
    .io_addr(st_reg.addr_cfg[10:0]),
    .data_wait_count(st_reg.wait_cfg[`EMS_WAIT_DATA_LSB +: 3]),
    .io_region_wait_counts(st_reg.wait_cfg[`EMS_WAIT_IO_LSB +: 3*REGIONS]),
    .wait_cycles(wait_cycles)
  );

  // APB access phase is answered one cycle later, pready comes from a register
  assign apb_take = apb_req.psel && apb_req.penable && !st_reg.rsp.pready;
  assign req_go = apb_take && apb_req.pwrite && apb_req.paddr == `EMS_OFF_REQ;
  assign req_space = apb_req.pwdata[3:0];

  // Next-state logic
  always_comb begin
    st_next = st_reg;
    sel_vec = 4'h0;
    st_next.rsp.pready = apb_take;
    st_next.rsp.pslverr = 1'b0;
    st_next.rsp.prdata = `EMS_UNMAPPED;
    st_next.done = 1'b0;
    // Catch the mode straps on the first edge after reset release
    if (!st_reg.caught) begin
      st_next.caught = 1'b1;
      st_next.host_mode = mode_pin_in; // RL1 RL18
      st_next.ack_mode = ack_strap;
    end
    // Pin is released to flag duty after the catch; outside driver is gone by then
    st_next.flag_oe = st_reg.caught; // RL1 RL2
    // Acknowledge drive style in host mode
    if (st_reg.host_mode && st_reg.ack_mode) begin
      st_next.ack_out = 1'b1; // RL4
      st_next.ack_oe_n = !host_port_ack_req;
    end else begin
      st_next.ack_out = host_port_ack_req; // RL3
      st_next.ack_oe_n = !st_reg.host_mode;
    end
    // Register writes and reads
    if (apb_take && apb_req.pwrite) begin
      if (apb_req.paddr == `EMS_OFF_WAIT) begin
        st_next.wait_cfg = apb_req.pwdata[15:0];
      end else if (apb_req.paddr == `EMS_OFF_SELCTL) begin
        st_next.sel_cfg = apb_req.pwdata[4:0]; // RL19
      end else if (apb_req.paddr == `EMS_OFF_OVLAY) begin
        st_next.ovl_cfg = apb_req.pwdata[7:0];
      end else if (apb_req.paddr == `EMS_OFF_ADDR) begin
        st_next.addr_cfg = apb_req.pwdata;
      end else if (apb_req.paddr == `EMS_OFF_FLAG) begin
        st_next.flag_out = apb_req.pwdata[0];
      end else if (apb_req.paddr != `EMS_OFF_REQ) begin
        st_next.rsp.pslverr = 1'b1;
      end
    end else if (apb_take) begin
      if (apb_req.paddr == `EMS_OFF_WAIT) begin
        st_next.rsp.prdata = {16'h0000, st_reg.wait_cfg};
      end else if (apb_req.paddr == `EMS_OFF_SELCTL) begin
        st_next.rsp.prdata = {27'h0, st_reg.sel_cfg};
      end else if (apb_req.paddr == `EMS_OFF_OVLAY) begin
        st_next.rsp.prdata = {24'h0, st_reg.ovl_cfg};
      end else if (apb_req.paddr == `EMS_OFF_ADDR) begin
        st_next.rsp.prdata = st_reg.addr_cfg;
      end else if (apb_req.paddr == `EMS_OFF_STATUS) begin
        st_next.rsp.prdata = {24'h0, st_reg.state != ST_IDLE, st_reg.granted, st_reg.ack_mode,
                              st_reg.host_mode, st_reg.count};
      end else if (apb_req.paddr == `EMS_OFF_FLAG) begin
        st_next.rsp.prdata = {31'h0, mode_pin_in};
      end else begin
        st_next.rsp.pslverr = 1'b1;
      end
    end
    // Bus grant releases every select
    st_next.granted = bus_request && st_reg.state == ST_IDLE; // RL16
    case (st_reg.state)
      ST_IDLE: begin
        st_next.sel = '1;
        st_next.rd_n = 1'b1;
        st_next.wr_n = 1'b1;
        if (req_go && !bus_request && !st_reg.granted) begin
          st_next.space = req_space;
          st_next.is_write = apb_req.pwdata[4];
          st_next.state = ST_WAIT;
          st_next.count = 4'h0;
        end else if (req_go) begin
          st_next.rsp.pslverr = 1'b1; // RL16
        end
      end
      ST_WAIT: begin
        // Decide external or internal on the first wait cycle
        st_next.ext_hit = cur_io || (st_reg.space == EMS_SPACE_BYTE) ||
                          (ovl_ext && (!st_reg.host_mode || !cur_prog)); // RL6 RL12
        if (!st_next.ext_hit) begin
          st_next.state = ST_DONE; // RL9 RL5
        end else begin
          sel_vec = {cur_io, st_reg.space == EMS_SPACE_BYTE && st_reg.sel_cfg[`EMS_BYTE_SEL_EN_BIT],
                     st_reg.space == EMS_SPACE_DATA, cur_prog};
          st_next.sel.prog_n = !sel_vec[0]; // RL14
          st_next.sel.data_n = !sel_vec[1];
          st_next.sel.byte_n = !sel_vec[2];
          st_next.sel.io_n = !sel_vec[3];
          st_next.sel.comb_n = !(|(sel_vec & st_reg.sel_cfg[3:0]) ||
                                 (st_reg.space == EMS_SPACE_BYTE && st_reg.sel_cfg[`EMS_EN_BYTE])); // RL15
          st_next.rd_n = st_reg.is_write;
          st_next.wr_n = !st_reg.is_write;
          if (cur_io) begin
            st_next.addr = {3'b000, st_reg.addr_cfg[10:0]}; // RL12
          end else if (st_reg.host_mode) begin
            st_next.addr = {13'h0, ovl_a13}; // RL6
          end else begin
            st_next.addr = {ovl_a13, st_reg.addr_cfg[12:0]}; // RL7 RL8
          end
          // Hold selects until waits are used up
          if (st_reg.count == wait_cycles && !st_reg.sel.comb_n | !st_reg.sel.prog_n | !st_reg.sel.data_n |
              !st_reg.sel.byte_n | !st_reg.sel.io_n) begin
            st_next.state = ST_DONE; // RL10 RL20
            st_next.sel = '1;
            st_next.rd_n = 1'b1;
            st_next.wr_n = 1'b1;
          end else if (!(&{st_reg.sel.prog_n, st_reg.sel.data_n, st_reg.sel.byte_n, st_reg.sel.io_n,
                           st_reg.sel.comb_n})) begin
            st_next.count = st_reg.count + 4'h1; // RL20
          end
        end
      end
      ST_DONE: begin
        st_next.sel = '1;
        st_next.rd_n = 1'b1;
        st_next.wr_n = 1'b1;
        st_next.done = 1'b1;
        st_next.state = ST_IDLE;
      end
      default: begin
        st_next.state = ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
      st_reg.state <= ST_IDLE;
      st_reg.wait_cfg <= 16'(`EMS_WAIT_RESET);
      st_reg.sel_cfg <= {1'b1, `EMS_SELCTL_RESET}; // RL17 RL19
      st_reg.sel <= '1;
      st_reg.rd_n <= 1'b1;
      st_reg.wr_n <= 1'b1;
      st_reg.ack_oe_n <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from flip-flops
  assign apb_rsp = st_reg.rsp;
  assign flag_pin_two_out = st_reg.flag_out;
  assign flag_pin_two_oe_n = !st_reg.flag_oe;
  assign host_port_ack_out = st_reg.ack_out;
  assign host_port_ack_oe_n = st_reg.ack_oe_n;
  assign bus_grant = st_reg.granted;
  assign selects = st_reg.sel;
  assign ext_addr = st_reg.addr;
  assign rd_strobe_n = st_reg.rd_n;
  assign wr_strobe_n = st_reg.wr_n;
  assign access_done = st_reg.done;
endmodule

/* hdl/ems_wait_calc.sv */
// Wait-state count from the data and io wait fields and the mode bit
`timescale 1ns/10ps
`include "ems_defines.svh"
module ems_wait_calc #(
  parameter int REGIONS = 4
) (
  input wire logic wait_mode,
  input wire logic is_io,
  input wire logic [10:0] io_addr,
  input wire logic [2:0] data_wait_count,
  input wire logic [3*REGIONS-1:0] io_region_wait_counts,
  output logic [3:0] wait_cycles
);
  logic [2:0] n;
  logic [1:0] region;
  initial begin
    if (REGIONS != 4) $error("ems_wait_calc: four io regions only");
  end
  // Pick the field: io by region of address bits 10:9, else data
  always_comb begin
    region = io_addr[10:9]; // RL13
    n = is_io ? io_region_wait_counts[3*region +: 3] : data_wait_count; // RL10
    // Normal N, or 2N+1 up to 15
    wait_cycles = wait_mode ? {n, 1'b1} : {1'b0, n}; // RL11
  end
endmodule

/* tb/ems_assertions.sv */
// Checker of select timing, overlay decode and pin drive
`timescale 1ns/10ps
module ems_assertions import ems_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire ems_pkg::ems_apb_req_t apb_req,
  input wire ems_pkg::ems_apb_rsp_t apb_rsp,
  input wire logic mode_pin_in,
  input wire logic ack_strap,
  input wire logic host_port_ack_out,
  input wire logic host_port_ack_oe_n,
  input wire logic bus_grant,
  input wire ems_pkg::ems_sel_t selects,
  input wire logic [13:0] ext_addr,
  input wire logic rd_strobe_n,
  input wire logic wr_strobe_n
);
  logic [15:0] wt;
  logic [4:0] en;
  logic [4:0] run;
  logic [6:0] ov;
  logic [1:0] up;
  logic [1:0] rg;
  logic host;
  logic strap;
  logic wr;
  assign wr = apb_req.psel & apb_req.penable & apb_req.pwrite & apb_rsp.pready;
  // Shadow of written fields, strap capture, select run length
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wt <= 16'h7fff;
      en <= 5'h1b;
      ov <= 7'h00;
      run <= 5'h00;
      up <= 2'h0;
      rg <= 2'h0;
      host <= 1'b0;
      strap <= 1'b0;
    end else begin
      if (wr && apb_req.paddr == 12'h000) wt <= apb_req.pwdata[15:0];
      if (wr && apb_req.paddr == 12'h004) en <= apb_req.pwdata[4:0];
      if (wr && apb_req.paddr == 12'h008) ov <= apb_req.pwdata[6:0];
      run <= (!selects.data_n || !selects.io_n) ? run + 5'h1 : 5'h00;
      if (run == 5'h00) rg <= ext_addr[10:9];
      if (up != 2'h3) up <= up + 2'h1;
      if (up == 2'h0) host <= mode_pin_in;
      if (up == 2'h0) strap <= ack_strap;
    end
  end
  // Select time for a field value: wait states plus one
  function automatic logic [4:0] ws(input logic [2:0] n);
    ws = wt[15] ? {1'b0, n, 1'b1} + 5'h1 : {2'h0, n} + 5'h1;
  endfunction
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_data_len;
    $rose(selects.data_n) |-> run == ws(wt[14:12]);
  endproperty
  a_data_len: assert property (p_data_len) else $error("data select length wrong");
  property p_io_len;
    $rose(selects.io_n) |-> run == ws(wt[3*rg +: 3]);
  endproperty
  a_io_len: assert property (p_io_len) else $error("io select length wrong");
  property p_comb;
    en[4] |-> selects.comb_n == !((en[0] & !selects.prog_n) | (en[1] & !selects.data_n)
      | (en[2] & !selects.byte_n) | (en[3] & !selects.io_n));
  endproperty
  a_comb: assert property (p_comb) else $error("combined select mismatch");
  property p_ovl_p;
    !selects.prog_n |-> (ov[2:0] == 3'h1 && !ext_addr[13]) || (ov[2:0] == 3'h2 && ext_addr[13]);
  endproperty
  a_ovl_p: assert property (p_ovl_p) else $error("program overlay decode wrong");
  property p_hold;
    !selects.data_n && !$past(selects.data_n) |-> $stable(ext_addr) && $stable(rd_strobe_n) && $stable(wr_strobe_n);
  endproperty
  a_hold: assert property (p_hold) else $error("address or strobe moved during access");
  property p_grant;
    bus_grant |-> selects == 5'h1f;
  endproperty
  a_grant: assert property (p_grant) else $error("select active while bus granted");
  property p_ack;
    up == 2'h3 && host && !strap |-> !host_port_ack_oe_n;
  endproperty
  a_ack: assert property (p_ack) else $error("acknowledge not driven");
  property p_ack_os;
    up == 2'h3 && host && strap |-> host_port_ack_oe_n || host_port_ack_out;
  endproperty
  a_ack_os: assert property (p_ack_os) else $error("acknowledge driven low");
  cover property ($rose(selects.io_n));
  cover property ($rose(selects.prog_n));
  cover property (bus_grant);
endmodule
bind ems_top ems_assertions u_chk (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .mode_pin_in(mode_pin_in), .ack_strap(ack_strap), .host_port_ack_out(host_port_ack_out),
  .host_port_ack_oe_n(host_port_ack_oe_n), .bus_grant(bus_grant), .selects(selects), .ext_addr(ext_addr),
  .rd_strobe_n(rd_strobe_n), .wr_strobe_n(wr_strobe_n));

/* tb/ems_mem_model.sv */
// External memory side: select watcher and mode level driver
`timescale 1ns/10ps
module ems_mem_model import ems_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clr,
  input wire ems_pkg::ems_sel_t selects,
  input wire logic [13:0] ext_addr,
  output logic mode_oe,
  output logic [4:0] len,
  output ems_pkg::ems_sel_t seen,
  output logic a13
);
  // Mode driver enabled only while reset is low
  assign mode_oe = !presetn;
  // Select time and selects seen since the last clear
  always_ff @(posedge pclk) begin
    if (clr) begin
      len <= 5'h00;
      seen <= 5'h1f;
    end else if (selects != 5'h1f) begin
      len <= len + 5'h1;
      seen <= seen & selects;
      a13 <= ext_addr[13];
    end
  end
endmodule

/* tb/tb_ems_top.sv */
// Bench of the external memory select block
`timescale 1ns/10ps
module tb_ems_top;
  import ems_pkg::*;
  logic pclk, presetn, host, strap, ackreq, busreq, clr, e, x, m_oe, a13, f_out, f_oe_n, a_out, a_oe_n;
  logic bus_grant, rd_n, wr_n, access_done, fpin, apin;
  logic [31:0] q;
  logic [4:0] len;
  logic [13:0] ext_addr;
  ems_apb_req_t req;
  ems_apb_rsp_t rsp;
  ems_sel_t selects, seen;
  int num_errors = 0;
  int n_compared = 0;
  // Mode pin: driver during reset, weak pull to the mode level after; ack pin pull-down
  assign fpin = !f_oe_n ? f_out : host;
  assign apin = !a_oe_n ? a_out : 1'b0;
  ems_top dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp), .mode_pin_in(fpin),
    .ack_strap(strap), .flag_pin_two_out(f_out), .flag_pin_two_oe_n(f_oe_n), .host_port_ack_req(ackreq),
    .host_port_ack_out(a_out), .host_port_ack_oe_n(a_oe_n), .bus_request(busreq), .bus_grant(bus_grant),
    .selects(selects), .ext_addr(ext_addr), .rd_strobe_n(rd_n), .wr_strobe_n(wr_n), .access_done(access_done));
  ems_mem_model mdl (.pclk(pclk), .presetn(presetn), .clr(clr), .selects(selects), .ext_addr(ext_addr),
    .mode_oe(m_oe), .len(len), .seen(seen), .a13(a13));
  task results;
    if (num_errors == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
    n_compared++;
    if (g !== ex) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, ex, g);
    end
  endtask
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    @(posedge pclk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    req.penable <= 1'b1;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (rsp.pready !== 1'b1 && t < 50);
    if (t >= 50) num_errors++;
    q = rsp.prdata;
    e = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task acc(input logic [3:0] sp, input logic [4:0] s);
    int t;
    clr <= 1'b1;
    bus(1'b1, 12'h010, {28'h0, sp});
    clr <= 1'b0;
    t = 0;
    while (access_done !== 1'b1 && t < 60) begin
      @(posedge pclk);
      t++;
    end
    chk("done", 1, access_done);
    @(posedge pclk);
    chk("selects", s, seen);
  endtask
  task rst(input logic h, input logic s);
    presetn <= 1'b0;
    host <= h;
    strap <= s;
    repeat (20) @(posedge pclk);
    chk("mode_oe", 1, m_oe);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  initial begin
    #800000;
    num_errors++;
    results();
  end
  initial begin
    {presetn, host, strap, ackreq, busreq, clr} = 6'h0;
    req = '0;
    rst(1'b0, 1'b0);
    bus(1'b0, 12'h000, 0);
    chk("wait", 32'h7fff, q);
    bus(1'b0, 12'h004, 0);
    chk("selctl", 32'h1b, q);
    bus(1'b0, 12'h0fc, 0);
    chk("slverr", 1, e);
    bus(1'b1, 12'h000, 0);
    bus(1'b1, 12'h014, 32'h2abc);
    // Every overlay code on program and data space
    for (int p = 0; p < 2; p++) for (int v = 0; v < 8; v++) begin
      bus(1'b1, 12'h008, 32'(v) << (p * 4));
      x = (v == 1 || v == 2);
      acc(p ? 4'h2 : 4'h1, !x ? 5'h1f : p ? 5'b10110 : 5'b01110);
      chk("len", x, len);
      if (x) chk("a13", v == 2, a13);
    end
    bus(1'b1, 12'h008, 32'h10);
    // Data wait states at field ends in both modes
    for (int m = 0; m < 2; m++) for (int n = 0; n < 8; n += 7) begin
      bus(1'b1, 12'h000, 32'((m << 15) | (n << 12)));
      acc(4'h2, 5'b10110);
      chk("len", m ? 2 * n + 2 : n + 1, len);
    end
    // Each io region with its own field
    bus(1'b1, 12'h000, 32'h08d1);
    for (int r = 0; r < 4; r++) begin
      bus(1'b1, 12'h014, 32'(r * 512 + 5));
      acc(4'h8, 5'b11100);
      chk("len", r + 2, len);
    end
    bus(1'b1, 12'h004, 32'h11);
    acc(4'h2, 5'b10111);
    bus(1'b1, 12'h004, 32'h04);
    acc(4'h4, 5'b11110);
    busreq <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("grant", 1, bus_grant);
    bus(1'b1, 12'h010, 32'h2);
    chk("refused", 1, e);
    busreq <= 1'b0;
    bus(1'b1, 12'h018, 32'h1);
    repeat (2) @(posedge pclk);
    chk("flag", 1, fpin);
    bus(1'b1, 12'h018, 32'h0);
    repeat (2) @(posedge pclk);
    chk("flag", 0, fpin);
    rst(1'b1, 1'b0);
    ackreq <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("ack", 1, apin);
    ackreq <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("ack_oe_n", 0, a_oe_n);
    rst(1'b1, 1'b1);
    repeat (3) @(posedge pclk);
    chk("ack_oe_n", 1, a_oe_n);
    ackreq <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("ack", 1, apin);
    results();
  end
endmodule
